// *** hw/acc_params.svh ***
// constants of the analog comparator control block: offsets, field positions, resets
// assumes inclusion by each design file that needs a figure
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// ---------------------------------------------------------------
// register offsets (byte addresses on the 8-bit register port)
// ---------------------------------------------------------------
`define ACC_OFS_CTRL_STATUS   8'h50
`define ACC_OFS_CONV_B        8'h7B
`define ACC_OFS_DIN_DISABLE   8'h7F
`define ACC_OFS_OUT_ENABLE    8'h51
`define ACC_OFS_CONV_A        8'h7A
`define ACC_OFS_CONV_CHANNEL  8'h7C
`define ACC_OFS_VECTOR_ACK    8'h52

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define ACC_BIT_POWER_OFF     7
`define ACC_BIT_BANDGAP       6
`define ACC_BIT_RESULT        5
`define ACC_BIT_FLAG          4
`define ACC_BIT_IRQ_EN        3
`define ACC_BIT_CAPTURE       2
`define ACC_BIT_MODE_HI       1
`define ACC_BIT_MODE_LO       0
`define ACC_BIT_MUX_EN        6
`define ACC_BIT_CONV_EN       7
`define ACC_BIT_PIN_OE        0
`define ACC_BIT_NEG_BUF_OFF   1
`define ACC_BIT_POS_BUF_OFF   0

// ---------------------------------------------------------------
// reset values and masks
// ---------------------------------------------------------------
`define ACC_RST_BYTE          8'h00
`define ACC_MASK_CONV_B       8'h47
`define ACC_MASK_DIN_DISABLE  8'h03
`define ACC_MASK_OUT_ENABLE   8'h01
`define ACC_MASK_CHANNEL      8'h07

// ---------------------------------------------------------------
// timing: synchroniser depth in cycles
// ---------------------------------------------------------------
`define ACC_SYNC_STAGES       2

`endif

// *** hw/acc_pkg.sv ***
// types shared by the analog comparator control block
// assumes acc_params.svh lies on the include path
package acc_pkg;

    // ---------------------------------------------------------------
    // event mode encoding
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        ACC_MODE_TOGGLE   = 2'b00,
        ACC_MODE_RESERVED = 2'b01,
        ACC_MODE_FALL     = 2'b10,
        ACC_MODE_RISE     = 2'b11
    } acc_mode_type;

    // ---------------------------------------------------------------
    // register port request, one cycle
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;   // byte address
        logic [7:0] wdata;  // write data
        logic       wr;     // write strobe
        logic       rd;     // read strobe
    } acc_bus_type;

    // ---------------------------------------------------------------
    // analog routing toward the comparator core
    // ---------------------------------------------------------------
    typedef struct packed {
        logic       power_off;   // core unpowered
        logic       bandgap_sel; // positive input from bandgap
        logic       neg_from_mux;// negative input from converter pin
        logic [2:0] neg_channel; // which converter pin
    } acc_route_type;

endpackage : acc_pkg

// *** hw/acc_sync.sv ***
// two-stage synchroniser for the raw comparator level
// assumes the raw level may change at any time relative to the clock
`timescale 1ns/1ps
module acc_sync #(
    parameter int STAGES = 2    // depth, at least two
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // level in and out
    input  wire logic async_i,
    output wire logic sync_o
);
    logic [STAGES-1:0] chain;       // first stage read only by the second
    logic [STAGES-1:0] next_chain;  // shifted chain

    // shift in the raw level
    always_comb begin
        next_chain = {chain[STAGES-2:0], async_i};
    end

    // register the chain
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            chain <= '0;
        end else begin
            chain <= next_chain;
        end
    end

    assign sync_o = chain[STAGES-1];
endmodule : acc_sync

// *** hw/acc_edge.sv ***
// event detector: compares the synced result with its previous cycle
// assumes the input is already in the clock domain
`timescale 1ns/1ps
module acc_edge
    import acc_pkg::*;
(
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // synced level and selected mode
    input  wire logic         level_i,
    input  wire acc_mode_type mode_i,
    // one-cycle event pulse
    output wire logic         event_o
);
    logic prev;        // level one cycle ago
    logic next_prev;   // next value
    logic hit;         // mode match this cycle

    // decode the selected event
    always_comb begin
        next_prev = level_i;
        unique case (mode_i)
            ACC_MODE_TOGGLE:   hit = level_i ^ prev;
            ACC_MODE_RESERVED: hit = 1'b0;         // reserved code never fires
            ACC_MODE_FALL:     hit = prev & ~level_i;
            ACC_MODE_RISE:     hit = ~prev & level_i;
        endcase
    end

    // remember last level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev <= 1'b0;
        end else begin
            prev <= next_prev;
        end
    end

    assign event_o = hit;
endmodule : acc_edge

// *** hw/acc_ctrl.sv ***
// top of the analog comparator control block: registers, routing, event flag
// assumes an 8-bit register port with read data one cycle after the read strobe
//
// Notes on behaviour
// - raw result high when positive exceeds negative
// - mux on, converter off: channel picks pin
// - otherwise negative pin feeds negative input
// - output enable drives result onto pin
// - power-off bit cuts comparator power anytime
// - bandgap select replaces positive pin
// - result bit synchronised, one-two cycle latency
// - selected event sets the flag
// - flag cleared by vector or written one
// - irq when flag, enable, global enable
// - mode: toggle, reserved, falling, rising
// - capture enable routes result to timer
// - buffer-off bits disable buffers, pins read zero
// - unused bits ignore writes, read zero, except in conv_a and channel, which store every bit
// - converter enable gates negative multiplexing
`timescale 1ns/1ps
`include "acc_params.svh"
module acc_ctrl
    import acc_pkg::*;
(
    // clock and reset
    input  wire logic          MCLK_I,
    input  wire logic          RST_I,
    // register port
    input  wire logic [7:0]    ADDR_I,
    input  wire logic [7:0]    WDATA_I,
    input  wire logic          WR_I,
    input  wire logic          RD_I,
    output logic      [7:0]    RDATA_O,
    // comparator core
    input  wire logic          RAW_RESULT_I,
    output acc_route_type      ROUTE_O,
    // interrupt system
    input  wire logic          GLOBAL_IRQ_EN_I,
    input  wire logic          VECTOR_ACK_I,
    output logic               IRQ_O,
    // timer capture front end and result pin
    output logic               CAPTURE_O,
    output logic               RESULT_PIN_O,
    output logic               RESULT_PIN_OE_O,
    // digital pin buffers
    input  wire logic          POS_PIN_DIN_I,
    input  wire logic          NEG_PIN_DIN_I,
    output logic               POS_PIN_DIN_O,
    output logic               NEG_PIN_DIN_O,
    output logic               POS_BUF_OFF_O,
    output logic               NEG_BUF_OFF_O
);
    // ---------------------------------------------------------------
    // register state
    // ---------------------------------------------------------------
    logic [7:0]   ctrl;            // control/status, flag and result bits unused
    logic [7:0]   conv_b;          // mux enable and trigger bits
    logic [7:0]   conv_a;          // converter enable lives in bit 7
    logic [7:0]   channel;         // channel select in low three bits
    logic [7:0]   din_off;         // buffer-off bits
    logic [7:0]   out_en;          // result pin enable
    logic         flag;            // event flag
    logic [7:0]   rdata;           // read data register
    logic [7:0]   next_ctrl;
    logic [7:0]   next_conv_b;
    logic [7:0]   next_conv_a;
    logic [7:0]   next_channel;
    logic [7:0]   next_din_off;
    logic [7:0]   next_out_en;
    logic         next_flag;
    logic [7:0]   next_rdata;

    // ---------------------------------------------------------------
    // output pipeline state
    // ---------------------------------------------------------------
    acc_route_type route;          // registered routing
    acc_route_type next_route;
    logic         irq;
    logic         next_irq;
    logic         capture;
    logic         next_capture;
    logic         pin;
    logic         next_pin;
    logic         pin_oe;
    logic         next_pin_oe;
    logic         pos_din;
    logic         neg_din;
    logic         next_pos_din;
    logic         next_neg_din;

    // ---------------------------------------------------------------
    // synchroniser and event detector
    // ---------------------------------------------------------------
    logic         result_sync;     // result in clock domain
    logic         event_hit;       // selected event this cycle

    // raw result comes from the core comparing selected inputs
    acc_sync #(.STAGES(`ACC_SYNC_STAGES)) u_sync (
        .clk_i   (MCLK_I),
        .rst_i   (RST_I),
        .async_i (RAW_RESULT_I),
        .sync_o  (result_sync)
    );

    acc_edge u_edge (
        .clk_i   (MCLK_I),
        .rst_i   (RST_I),
        .level_i (result_sync),
        .mode_i  (acc_mode_type'(ctrl[`ACC_BIT_MODE_HI:`ACC_BIT_MODE_LO])),
        .event_o (event_hit)
    );

    // ---------------------------------------------------------------
    // register writes, flag and read data
    // ---------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    always_comb begin
        next_ctrl    = ctrl;
        next_conv_b  = conv_b;
        next_conv_a  = conv_a;
        next_channel = channel;
        next_din_off = din_off;
        next_out_en  = out_en;
        next_flag    = flag;
        next_rdata   = `ACC_RST_BYTE;
        // clears first, so a same-cycle event below still wins
        if (VECTOR_ACK_I) begin
            next_flag = 1'b0;
        end
        if (WR_I) begin
            if (hit(ADDR_I, `ACC_OFS_CTRL_STATUS)) begin
                // result and flag bits are not stored here
                next_ctrl = WDATA_I & ~8'h30;
                if (WDATA_I[`ACC_BIT_FLAG]) begin
                    next_flag = 1'b0;
                end
            end
            if (hit(ADDR_I, `ACC_OFS_CONV_B)) begin
                next_conv_b = WDATA_I & `ACC_MASK_CONV_B;
            end
            if (hit(ADDR_I, `ACC_OFS_CONV_A)) begin
                next_conv_a = WDATA_I;
            end
            if (hit(ADDR_I, `ACC_OFS_CONV_CHANNEL)) begin
                next_channel = WDATA_I;
            end
            if (hit(ADDR_I, `ACC_OFS_DIN_DISABLE)) begin
                next_din_off = WDATA_I & `ACC_MASK_DIN_DISABLE;
            end
            if (hit(ADDR_I, `ACC_OFS_OUT_ENABLE)) begin
                next_out_en = WDATA_I & `ACC_MASK_OUT_ENABLE;
            end
        end
        // hardware set beats any clear
        if (event_hit) begin
            next_flag = 1'b1;
        end
        if (RD_I) begin
            unique case (ADDR_I)
                `ACC_OFS_CTRL_STATUS: begin
                    next_rdata = ctrl;
                    next_rdata[`ACC_BIT_RESULT] = result_sync;
                    next_rdata[`ACC_BIT_FLAG]   = flag;
                end
                `ACC_OFS_CONV_B:       next_rdata = conv_b;
                `ACC_OFS_CONV_A:       next_rdata = conv_a;
                `ACC_OFS_CONV_CHANNEL: next_rdata = channel;
                `ACC_OFS_DIN_DISABLE:  next_rdata = din_off;
                `ACC_OFS_OUT_ENABLE:   next_rdata = out_en;
                default:               next_rdata = `ACC_RST_BYTE; // unmapped
            endcase
        end
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            ctrl    <= `ACC_RST_BYTE;
            conv_b  <= `ACC_RST_BYTE;
            conv_a  <= `ACC_RST_BYTE;
            channel <= `ACC_RST_BYTE;
            din_off <= `ACC_RST_BYTE;
            out_en  <= `ACC_RST_BYTE;
            flag    <= 1'b0;
            rdata   <= `ACC_RST_BYTE;
        end else begin
            ctrl    <= next_ctrl;
            conv_b  <= next_conv_b;
            conv_a  <= next_conv_a;
            channel <= next_channel;
            din_off <= next_din_off;
            out_en  <= next_out_en;
            flag    <= next_flag;
            rdata   <= next_rdata;
        end
    end

    // ---------------------------------------------------------------
    // routing, interrupt, capture, pins
    // ---------------------------------------------------------------
    always_comb begin
        next_route.power_off   = ctrl[`ACC_BIT_POWER_OFF];
        next_route.bandgap_sel = ctrl[`ACC_BIT_BANDGAP];
        // converter must be off for the mux to take the negative input
        next_route.neg_from_mux = conv_b[`ACC_BIT_MUX_EN]
                                & ~conv_a[`ACC_BIT_CONV_EN];
        next_route.neg_channel = next_route.neg_from_mux
                               ? channel[2:0] : 3'h0;
        next_irq     = flag & ctrl[`ACC_BIT_IRQ_EN] & GLOBAL_IRQ_EN_I;
        next_capture = ctrl[`ACC_BIT_CAPTURE] & result_sync;
        next_pin_oe  = out_en[`ACC_BIT_PIN_OE];
        next_pin     = out_en[`ACC_BIT_PIN_OE] & result_sync;
        next_pos_din = POS_PIN_DIN_I & ~din_off[`ACC_BIT_POS_BUF_OFF];
        next_neg_din = NEG_PIN_DIN_I & ~din_off[`ACC_BIT_NEG_BUF_OFF];
    end

    always_ff @(posedge MCLK_I) begin
        if (RST_I) begin
            route   <= '0;
            irq     <= 1'b0;
            capture <= 1'b0;
            pin     <= 1'b0;
            pin_oe  <= 1'b0;
            pos_din <= 1'b0;
            neg_din <= 1'b0;
        end else begin
            route   <= next_route;
            irq     <= next_irq;
            capture <= next_capture;
            pin     <= next_pin;
            pin_oe  <= next_pin_oe;
            pos_din <= next_pos_din;
            neg_din <= next_neg_din;
        end
    end

    assign RDATA_O         = rdata;
    assign ROUTE_O         = route;
    assign IRQ_O           = irq;
    assign CAPTURE_O       = capture;
    assign RESULT_PIN_O    = pin;
    assign RESULT_PIN_OE_O = pin_oe;
    assign POS_PIN_DIN_O   = pos_din;
    assign NEG_PIN_DIN_O   = neg_din;
    assign POS_BUF_OFF_O   = din_off[`ACC_BIT_POS_BUF_OFF];
    assign NEG_BUF_OFF_O   = din_off[`ACC_BIT_NEG_BUF_OFF];

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    flag_set_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        event_hit |=> flag)
        else $error("event did not set flag");
    flag_clear_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        (VECTOR_ACK_I && !event_hit) |=> !flag)
        else $error("vector did not clear flag");
    irq_gate_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        IRQ_O |-> $past(flag) && $past(ctrl[3]) && $past(GLOBAL_IRQ_EN_I))
        else $error("irq without cause");
    sync_delay_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        $rose(RAW_RESULT_I) ##1 RAW_RESULT_I |=> result_sync)
        else $error("result sync too slow");
    neg_mux_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        conv_a[7] |=> !ROUTE_O.neg_from_mux)
        else $error("mux active with converter on");
    pin_drive_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        !out_en[0] |=> !RESULT_PIN_OE_O && !RESULT_PIN_O)
        else $error("pin driven while disabled");
    capture_off_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        !ctrl[2] |=> !CAPTURE_O)
        else $error("capture routed while off");
    buf_read_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        din_off[0] |=> !POS_PIN_DIN_O)
        else $error("disabled pin reads one");
    unused_zero_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        RD_I && ADDR_I == 8'h7F |=> RDATA_O[7:2] == 6'h00)
        else $error("unused bits read nonzero");
    bandgap_route_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        ROUTE_O.bandgap_sel == $past(ctrl[`ACC_BIT_BANDGAP]))
        else $error("bandgap select not routed");
    power_route_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        ROUTE_O.power_off == $past(ctrl[`ACC_BIT_POWER_OFF]))
        else $error("power off not routed");
    mux_select_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        conv_b[`ACC_BIT_MUX_EN] && !conv_a[`ACC_BIT_CONV_EN]
        |=> ROUTE_O.neg_from_mux && ROUTE_O.neg_channel == $past(channel[2:0]))
        else $error("converter pin not selected");
    result_read_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        RD_I && ADDR_I == `ACC_OFS_CTRL_STATUS
        |=> RDATA_O[`ACC_BIT_RESULT] == $past(result_sync))
        else $error("result bit not read back");
    rise_event_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        ctrl[`ACC_BIT_MODE_HI:`ACC_BIT_MODE_LO] == ACC_MODE_RISE && $rose(result_sync)
        |-> event_hit)
        else $error("rising edge missed");
    fall_event_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        ctrl[`ACC_BIT_MODE_HI:`ACC_BIT_MODE_LO] == ACC_MODE_FALL && $fell(result_sync)
        |-> event_hit)
        else $error("falling edge missed");
    reserved_mode_a: assert property (@(posedge MCLK_I) disable iff (RST_I)
        ctrl[`ACC_BIT_MODE_HI:`ACC_BIT_MODE_LO] == ACC_MODE_RESERVED |-> !event_hit)
        else $error("reserved mode raised an event");
endmodule : acc_ctrl

// *** dv/acc_core_model.sv ***
// behavioural analog comparator core facing the control block
// assumes millivolt levels driven by the bench and no settling delay
`timescale 1ns/1ps
module acc_core_model
    import acc_pkg::*;
(
    // routing from the control block
    input  wire acc_route_type    route_i,
    // analog levels in millivolts
    input  wire logic [15:0]      pos_mv_i,
    input  wire logic [15:0]      neg_mv_i,
    input  wire logic [15:0]      bg_mv_i,
    input  wire logic [7:0][15:0] conv_mv_i,
    // raw comparator level
    output logic                  raw_o
);
    // ---------------------------------------------------------------
    // input selection and compare
    // ---------------------------------------------------------------
    logic [15:0] pos_sel; // level on the positive side
    logic [15:0] neg_sel; // level on the negative side

    // an unpowered core rests low rather than holding its last level
    always_comb begin
        pos_sel = route_i.bandgap_sel ? bg_mv_i : pos_mv_i;
        neg_sel = route_i.neg_from_mux ? conv_mv_i[route_i.neg_channel] : neg_mv_i;
        raw_o   = route_i.power_off ? 1'b0 : (pos_sel > neg_sel);
    end
endmodule : acc_core_model

// *** dv/acc_ctrl_test.sv ***
// self-checking bench for the comparator control block
// assumes the design files and the core model are compiled before it
`timescale 1ns/1ps
module acc_ctrl_test;
    import acc_pkg::*;
    // ---------------------------------------------------------------
    // signals and bench state
    // ---------------------------------------------------------------
    logic             clk, rst, wr, rd, gie, vack, pos_din, neg_din;
    logic [7:0]       addr, wdata, rdata, d;
    acc_route_type    route;
    logic             raw, irq, cap, pin, pin_oe, pos_dout, neg_dout, pos_off, neg_off;
    logic [15:0]      pos_mv, neg_mv, bg_mv;
    logic [7:0][15:0] conv_mv;
    int               n_errors, checks, me, ae, p, n, f;
    logic [7:0]       offs [7] = '{8'h50, 8'h7B, 8'h7F, 8'h51, 8'h7A, 8'h7C, 8'h60};
    logic [7:0]       mofs [3] = '{8'h7B, 8'h7F, 8'h51};
    logic [7:0]       msks [3] = '{8'h47, 8'h03, 8'h01};

    acc_ctrl i_acc_ctrl (
        .MCLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .RDATA_O(rdata), .RAW_RESULT_I(raw), .ROUTE_O(route),
        .GLOBAL_IRQ_EN_I(gie), .VECTOR_ACK_I(vack), .IRQ_O(irq), .CAPTURE_O(cap),
        .RESULT_PIN_O(pin), .RESULT_PIN_OE_O(pin_oe), .POS_PIN_DIN_I(pos_din),
        .NEG_PIN_DIN_I(neg_din), .POS_PIN_DIN_O(pos_dout), .NEG_PIN_DIN_O(neg_dout),
        .POS_BUF_OFF_O(pos_off), .NEG_BUF_OFF_O(neg_off));

    acc_core_model i_acc_core_model (
        .route_i(route), .pos_mv_i(pos_mv), .neg_mv_i(neg_mv), .bg_mv_i(bg_mv),
        .conv_mv_i(conv_mv), .raw_o(raw));

    // ---------------------------------------------------------------
    // tasks
    // ---------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one-cycle write strobe, released at the next edge
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask : wr_reg

    // read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask : rd_reg

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc

    // positive pin level changes just after an edge, like a real pin
    task automatic set_pos(input logic [15:0] v);
        @(posedge clk);
        pos_mv <= v;
    endtask : set_pos

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : test_done

    // ---------------------------------------------------------------
    // clock and watchdog
    // ---------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk);
        n_errors++;
        test_done();
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {wr, rd, gie, vack, pos_din, neg_din} = '0;
        addr = '0;
        wdata = '0;
        {pos_mv, neg_mv, bg_mv} = '0;
        conv_mv = '0;
        n_errors = 0;
        checks = 0;
        void'($urandom(32'h455ECF2D));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // reset values, unmapped place included
        foreach (offs[i]) begin
            rd_reg(offs[i]);
            chk("reset byte", d, 8'h00);
        end
        // unused bits ignore ones; unmapped writes are dropped
        foreach (mofs[i]) begin
            wr_reg(mofs[i], 8'hFF);
            rd_reg(mofs[i]);
            chk("masked byte", d, msks[i]);
            wr_reg(mofs[i], 8'h00);
        end
        wr_reg(8'h60, 8'hFF);
        rd_reg(8'h60);
        chk("unmapped", d, 8'h00);
        $display("test registers done");
        // converter power reduction taken as cleared outside
        for (int i = 0; i < 8; i++) begin
            me = $urandom % 2;
            ae = $urandom % 2;
            @(posedge clk);
            pos_mv <= 16'($urandom % 1000);
            neg_mv <= 16'($urandom % 1000);
            for (int k = 0; k < 8; k++)
                conv_mv[k] <= 16'($urandom % 1000);
            wr_reg(8'h7B, 8'(me << 6));
            wr_reg(8'h7A, 8'(ae << 7));
            wr_reg(8'h7C, 8'(i));
            cyc(4);
            f = me && !ae;
            chk("mux on", 8'(route.neg_from_mux), 8'(f));
            chk("channel", 8'(route.neg_channel), f ? 8'(i) : 8'h00);
            p = pos_mv;
            n = f ? conv_mv[i] : neg_mv;
            rd_reg(8'h50);
            chk("result", d & 8'h20, (p > n) ? 8'h20 : 8'h00);
        end
        wr_reg(8'h7B, 8'h00);
        $display("test routing done");
        // bandgap replaces the positive pin, then power off
        @(posedge clk);
        pos_mv <= 16'd0;
        neg_mv <= 16'd500;
        bg_mv  <= 16'd1200;
        wr_reg(8'h50, 8'h40);
        cyc(4);
        chk("bandgap", 8'(route.bandgap_sel), 8'h01);
        rd_reg(8'h50);
        chk("bg result", d & 8'h20, 8'h20);
        wr_reg(8'h50, 8'hC0);
        cyc(2);
        chk("power off", 8'(route.power_off), 8'h01);
        wr_reg(8'h50, 8'h00);
        cyc(4);
        // result bit within two cycles of the raw change
        set_pos(16'd800);
        @(posedge clk);
        rd_reg(8'h50);
        chk("sync", d & 8'h20, 8'h20);
        $display("test inputs done");
        // every mode; interrupt enable held clear across mode changes
        for (int m = 0; m < 4; m++) begin
            wr_reg(8'h50, 8'(m));
            set_pos(16'd100);
            cyc(5);
            wr_reg(8'h50, 8'(8'h10 | m));
            set_pos(16'd800);
            cyc(5);
            rd_reg(8'h50);
            f = (m == 0) || (m == 3);
            chk("rise flag", d & 8'h30, 8'(8'h20 | (f << 4)));
            wr_reg(8'h50, 8'(8'h10 | m));
            set_pos(16'd100);
            cyc(5);
            rd_reg(8'h50);
            f = (m == 0) || (m == 2);
            chk("fall flag", d & 8'h30, 8'(f << 4));
            chk("no irq", 8'(irq), 8'h00);
        end
        $display("test modes done");
        // request needs flag, enable and global enable
        wr_reg(8'h50, 8'h13);
        wr_reg(8'h50, 8'h0B);
        set_pos(16'd800);
        cyc(5);
        chk("irq global off", 8'(irq), 8'h00);
        @(posedge clk);
        gie <= 1'b1;
        cyc(3);
        chk("irq on", 8'(irq), 8'h01);
        @(posedge clk);
        vack <= 1'b1;
        @(posedge clk);
        vack <= 1'b0;
        cyc(3);
        chk("irq vector", 8'(irq), 8'h00);
        rd_reg(8'h50);
        chk("flag vector", d & 8'h10, 8'h00);
        set_pos(16'd100);
        cyc(5);
        set_pos(16'd800);
        cyc(5);
        chk("irq again", 8'(irq), 8'h01);
        wr_reg(8'h50, 8'h1B);
        cyc(3);
        chk("irq write one", 8'(irq), 8'h00);
        wr_reg(8'h50, 8'h03);
        $display("test interrupt done");
        // timer capture irq mask is set outside this block
        wr_reg(8'h51, 8'h01);
        wr_reg(8'h50, 8'h04);
        cyc(3);
        chk("capture high", 8'({cap, pin, pin_oe}), 8'h07);
        set_pos(16'd100);
        cyc(5);
        chk("capture low", 8'({cap, pin, pin_oe}), 8'h01);
        wr_reg(8'h50, 8'h00);
        wr_reg(8'h51, 8'h00);
        set_pos(16'd800);
        cyc(5);
        chk("capture off", 8'({cap, pin_oe}), 8'h00);
        $display("test outputs done");
        // buffer disables gate the pin levels to zero
        @(posedge clk);
        {pos_din, neg_din} <= 2'b11;
        for (int k = 0; k < 4; k++) begin
            wr_reg(8'h7F, 8'(k));
            cyc(3);
            f = {k[0], k[1], !k[0], !k[1]};
            chk("buffers", 8'({pos_off, neg_off, pos_dout, neg_dout}), 8'(f));
        end
        $display("test buffers done");
        test_done();
    end
endmodule : acc_ctrl_test
